//--- core/sem_pkg.sv
// package: constants and carrier types for the serial expansion port master
package sem_pkg;
  localparam int unsigned SEM_REF_CLK_HZ = 24_000_000;
  localparam int unsigned SEM_SCLK_MIN_HZ = 750_000;
  localparam int unsigned SEM_SCLK_MAX_HZ = 6_000_000;
  // half period in reference cycles: 24 MHz / 6 MHz / 2 = 2, 24 MHz / 0.75 MHz / 2 = 16
  localparam int unsigned SEM_HALF_MIN_I = SEM_REF_CLK_HZ / SEM_SCLK_MAX_HZ / 2;
  localparam int unsigned SEM_HALF_MAX_I = SEM_REF_CLK_HZ / SEM_SCLK_MIN_HZ / 2;
  localparam logic [4:0] SEM_HALF_MIN = SEM_HALF_MIN_I[4:0];
  localparam logic [4:0] SEM_HALF_MAX = SEM_HALF_MAX_I[4:0];
  localparam int unsigned SEM_DATA_W = 8;
  localparam logic [3:0] SEM_LAST_EDGE = 4'hF;
  localparam logic [7:0] SEM_RX_RST = 8'h00;

  typedef struct packed {
    logic cpol; // idle level of the serial clock
    logic cpha; // 1: data changes on the leading edge
    logic [4:0] half_div; // reference cycles per clock half
  } sem_cfg_t;

  typedef enum logic [3:0] {
    SEM_IDLE = 4'h1,
    SEM_SETUP = 4'h2,
    SEM_XFER = 4'h4,
    SEM_HOLD = 4'h8
  } sem_state_t;
endpackage

//--- core/sem_serial_expansion_port.sv
// serial expansion port master: byte transfers to one of two selectable slaves
`timescale 1ns/1ps
// Operation
// (R1) two active-low selects, select 0 and select 1, each addresses one peripheral
// (R2) the serial clock is driven only by this master
// (R3) every transfer begins only when the master is started
// (R4) a peripheral answers only while selected and clocked by the master
// (R5) software chooses the serial clock between 0.75 MHz and 6 MHz
// (R6) serial clock is the 24 MHz reference divided by an even count
// (R7) polarity and phase controls give all four clock modes
// (R8) data leaves on master-out and is captured from master-in
// (R9) at most one select low at once, both high when idle
module sem_serial_expansion_port (
  input wire logic I_SYS_CLK, // reference clock
  input wire logic I_RST_B, // synchronous reset, active low
  input wire sem_pkg::sem_cfg_t I_CFG, // mode and rate, taken at start
  input wire logic I_START, // one-cycle request, taken while idle
  input wire logic I_SEL, // which slave to address
  input wire logic [7:0] I_TX_DATA, // byte to send, msb first
  input wire logic I_MISO, // serial data from slave
  output logic O_SCLK, // serial clock
  output logic O_MOSI, // serial data to slave
  output logic O_SELECT_LINE_0_N, // select line 0, active low
  output logic O_SELECT_LINE_1_N, // select line 1, active low
  output logic O_BUSY, // transfer in progress
  output logic O_DONE, // one-cycle pulse at end of transfer
  output logic [7:0] O_RX_DATA // last byte received
);
  import sem_pkg::*;

  sem_state_t state_reg;
  logic cpol_reg;
  logic cpha_reg;
  logic sel_reg;
  logic [4:0] half_reg;
  logic [4:0] cnt_reg;
  logic [3:0] edge_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic tick;
  logic sample_edge;

  // out-of-range divisors are clamped so the rate never leaves the supported span
  function automatic logic [4:0] clamp_half(input logic [4:0] h);
    logic [4:0] r;
    r = h;
    if (h < SEM_HALF_MIN) begin
      r = SEM_HALF_MIN;
    end else if (h > SEM_HALF_MAX) begin
      r = SEM_HALF_MAX;
    end
    // odd counts are not possible here: a half period is a whole count of cycles
    return r;
  endfunction

  assign tick = (cnt_reg == 5'h00);
  assign sample_edge = (edge_reg[0] == cpha_reg);

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      state_reg <= SEM_IDLE;
    end else begin
      case (state_reg)
        SEM_IDLE: begin
          if (I_START) begin
            state_reg <= SEM_SETUP; // see (R3)
          end
        end
        SEM_SETUP: begin
          if (tick) begin
            state_reg <= SEM_XFER;
          end
        end
        SEM_XFER: begin
          if (tick && edge_reg == SEM_LAST_EDGE) begin
            state_reg <= SEM_HOLD;
          end
        end
        SEM_HOLD: begin
          if (tick) begin
            state_reg <= SEM_IDLE;
          end
        end
        default: begin
          state_reg <= SEM_IDLE;
        end
      endcase
    end
  end

  // configuration is frozen for the whole transfer
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      cpol_reg <= 1'b0;
      cpha_reg <= 1'b0;
      sel_reg <= 1'b0;
      half_reg <= SEM_HALF_MAX;
    end else if (state_reg == SEM_IDLE && I_START) begin
      cpol_reg <= I_CFG.cpol; // see (R7)
      cpha_reg <= I_CFG.cpha; // see (R7)
      sel_reg <= I_SEL;
      half_reg <= clamp_half(I_CFG.half_div); // see (R5)
    end
  end

  // half-period divider of the reference clock
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      cnt_reg <= 5'h00;
    end else if (state_reg == SEM_IDLE) begin
      cnt_reg <= clamp_half(I_CFG.half_div) - 5'h01; // see (R6)
    end else if (tick) begin
      cnt_reg <= half_reg - 5'h01; // see (R6)
    end else begin
      cnt_reg <= cnt_reg - 5'h01;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      edge_reg <= 4'h0;
    end else if (state_reg != SEM_XFER) begin
      edge_reg <= 4'h0;
    end else if (tick) begin
      edge_reg <= edge_reg + 4'h1;
    end
  end

  // sixteen toggles bring the clock back to its idle level
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      O_SCLK <= 1'b0;
    end else if (state_reg == SEM_IDLE) begin
      O_SCLK <= I_START ? I_CFG.cpol : cpol_reg; // see (R7)
    end else if (state_reg == SEM_XFER && tick) begin
      O_SCLK <= ~O_SCLK; // see (R2)
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      tx_reg <= 8'h00;
      O_MOSI <= 1'b0;
    end else if (state_reg == SEM_IDLE && I_START) begin
      tx_reg <= I_TX_DATA;
      O_MOSI <= I_CFG.cpha ? 1'b0 : I_TX_DATA[7]; // see (R8)
    end else if (state_reg == SEM_XFER && tick && !sample_edge
                 && edge_reg != SEM_LAST_EDGE) begin
      O_MOSI <= cpha_reg ? tx_reg[7] : tx_reg[6]; // see (R8)
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      rx_reg <= SEM_RX_RST;
    end else if (state_reg == SEM_XFER && tick && sample_edge) begin
      rx_reg <= {rx_reg[6:0], I_MISO}; // see (R8)
    end
  end

  // selects are released a half period after the last edge to give hold time
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      O_SELECT_LINE_0_N <= 1'b1;
      O_SELECT_LINE_1_N <= 1'b1;
    end else if (state_reg == SEM_IDLE && I_START) begin
      O_SELECT_LINE_0_N <= I_SEL; // see (R1)
      O_SELECT_LINE_1_N <= ~I_SEL; // see (R1)
    end else if (state_reg == SEM_HOLD && tick) begin
      O_SELECT_LINE_0_N <= 1'b1; // see (R9)
      O_SELECT_LINE_1_N <= 1'b1; // see (R9)
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      O_BUSY <= 1'b0;
      O_DONE <= 1'b0;
      O_RX_DATA <= SEM_RX_RST;
    end else begin
      O_DONE <= 1'b0;
      if (state_reg == SEM_IDLE && I_START) begin
        O_BUSY <= 1'b1;
      end else if (state_reg == SEM_HOLD && tick) begin
        O_BUSY <= 1'b0;
        O_DONE <= 1'b1;
        O_RX_DATA <= rx_reg;
      end
    end
  end

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_B);

  AST_SEL_MATCH: assert property ( // see (R1)
    (state_reg == SEM_XFER) |-> (O_SELECT_LINE_0_N == sel_reg) && (O_SELECT_LINE_1_N == !sel_reg))
    else $error("select line does not match the chosen slave");
  AST_SCLK_ONLY_XFER: assert property ( // see (R2)
    $changed(O_SCLK) && !$past(state_reg == SEM_IDLE) |-> $past(state_reg == SEM_XFER))
    else $error("serial clock moved outside a transfer");
  AST_NO_SELF_START: assert property ( // see (R3)
    (state_reg == SEM_IDLE) && !I_START |=>
      (state_reg == SEM_IDLE) && O_SELECT_LINE_0_N && O_SELECT_LINE_1_N)
    else $error("transfer began without a start request");
  AST_HALF_RANGE: assert property ( // see (R5)
    (half_reg >= SEM_HALF_MIN) && (half_reg <= SEM_HALF_MAX))
    else $error("clock divisor outside supported range");
  AST_HALF_MIN_WIDTH: assert property ( // see (R6)
    $changed(O_SCLK) && (state_reg == SEM_XFER) |=> $stable(O_SCLK))
    else $error("serial clock half period shorter than two reference cycles");
  AST_IDLE_LEVEL: assert property ( // see (R7)
    (state_reg == SEM_HOLD) |-> (O_SCLK == cpol_reg))
    else $error("serial clock not at its idle level after the last edge");
  AST_CAPTURE: assert property ( // see (R8)
    (state_reg == SEM_XFER) && tick && sample_edge |=> rx_reg[0] == $past(I_MISO))
    else $error("master-in bit not captured on the sampling edge");
  AST_ONE_SELECT: assert property ( // see (R9)
    (O_SELECT_LINE_0_N || O_SELECT_LINE_1_N)
      && (O_BUSY || (O_SELECT_LINE_0_N && O_SELECT_LINE_1_N)))
    else $error("both selects low or a select low while idle");

  COV_SEL0: cover property (O_DONE && !sel_reg);
  COV_SEL1: cover property (O_DONE && sel_reg);
  COV_MODE3: cover property (O_DONE && cpol_reg && cpha_reg);
  COV_FAST: cover property (O_DONE && half_reg == SEM_HALF_MIN);
endmodule

//--- test/sem_slave_model.sv
// spi peripheral model standing on the expansion port
`timescale 1ns/1ps
module sem_slave_model (
  input wire logic i_sclk, // serial clock from master
  input wire logic i_sel_n, // own select, active low
  input wire logic i_mosi, // data from master
  input wire logic i_cpol, // clock idle level
  input wire logic i_cpha, // clock phase
  input wire logic [7:0] i_byte, // byte to return
  output logic o_miso, // own data bit
  output logic [7:0] o_rx // byte captured
);
  int cnt = 0;
  wire sel_late_n;
  // select seen a moment late: the level jump in the select cycle is a mode change, not an edge
  assign #1 sel_late_n = i_sel_n;
  always @(posedge i_sel_n) cnt = 0;
  always @(i_sclk) begin
    if (!sel_late_n && i_sclk == (~i_cpol ^ i_cpha)) begin
      o_rx = {o_rx[6:0], i_mosi};
      cnt = cnt + 1;
    end
  end
  // bit moves on only after the master sampled it
  assign o_miso = i_byte[3'(7 - cnt)];
endmodule

//--- test/sem_serial_expansion_port_tb_top.sv
// self-checking bench of the serial expansion port master
`timescale 1ns/1ps
module sem_serial_expansion_port_tb_top;
  import sem_pkg::*;
  logic clk = 0;
  logic rst_b = 0;
  sem_cfg_t cfg = '0;
  logic start = 0;
  logic sel = 0;
  logic idle_bit = 0;
  logic [7:0] tx = 8'h00;
  logic [7:0] s_byte = 8'h00;
  logic sclk, mosi, select_line_0_n, select_line_1_n, busy, done, m0, m1;
  logic [7:0] rx, r0, r1;
  logic [15:0] q[$];
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int tog = 0;
  int gap = 0;
  logic msel = 0;
  logic pbusy = 0;
  logic psclk = 0;
  logic [4:0] h = 5'h02;
  // released line changes every cycle so a stale bit cannot pass
  wire miso = !select_line_0_n ? m0 : (!select_line_1_n ? m1 : idle_bit);
  wire [1:0] sel_pair_n = {select_line_1_n, select_line_0_n};
  always #25 clk = ~clk;
  always @(posedge clk) idle_bit <= ~idle_bit;
  sem_serial_expansion_port uut (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_CFG(cfg),
    .I_START(start), .I_SEL(sel), .I_TX_DATA(tx), .I_MISO(miso), .O_SCLK(sclk),
    .O_MOSI(mosi), .O_SELECT_LINE_0_N(select_line_0_n),
    .O_SELECT_LINE_1_N(select_line_1_n), .O_BUSY(busy), .O_DONE(done), .O_RX_DATA(rx));
  sem_slave_model s0 (.i_sclk(sclk), .i_sel_n(select_line_0_n), .i_mosi(mosi),
    .i_cpol(cfg.cpol),
    .i_cpha(cfg.cpha), .i_byte(s_byte), .o_miso(m0), .o_rx(r0));
  sem_slave_model s1 (.i_sclk(sclk), .i_sel_n(select_line_1_n), .i_mosi(mosi),
    .i_cpol(cfg.cpol),
    .i_cpha(cfg.cpha), .i_byte(s_byte), .o_miso(m1), .o_rx(r1));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checked %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task xfer(input sem_cfg_t c, input logic s, input logic b2b);
    logic [7:0] t, sb;
    t = 8'($urandom);
    sb = 8'($urandom);
    q.push_back({sb, t});
    cfg <= c;
    sel <= s;
    tx <= t;
    s_byte <= sb;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (3) @(posedge clk);
    // a start while busy must leave the running byte alone
    sel <= ~s;
    tx <= ~t;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (int n = 0; n < 400 && done !== 1'b1; n++) @(posedge clk);
    // a transfer that never finishes must not let the run pass
    chk({15'h0000, done}, 16'h0001);
    if (!b2b) repeat (2) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (rst_b === 1'b1) begin
      cyc++;
      if (pbusy && busy === 1'b1 && sclk !== psclk) begin
        if (tog > 0) chk(16'(gap), 16'(h));
        tog++;
        gap = 0;
      end
      gap++;
      chk(sel_pair_n, busy === 1'b1 ? (msel ? 2'h1 : 2'h2) : 2'h3);
      if (done === 1'b1) begin
        // start edge is cycle 0, done stands in cycle 18*h+1
        chk(16'(cyc), 16'(18 * h + 1));
        chk(16'(tog), 16'h0010);
        chk({rx, msel ? r1 : r0}, q.pop_front());
        tog = 0;
      end
      if (start === 1'b1 && busy !== 1'b1) begin
        cyc = 0;
        msel = sel;
        h = cfg.half_div < 5'h02 ? 5'h02 : (cfg.half_div > 5'h10 ? 5'h10 : cfg.half_div);
      end
    end
    pbusy = busy === 1'b1;
    psclk = sclk;
  end
  initial begin
    void'($urandom(8));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    // all modes, both selects, clamp bounds, every other byte back to back
    for (int i = 0; i < 12; i++) begin
      xfer({i[1], i[0], i == 8 ? 5'h00 : (i == 9 ? 5'h1F : 5'(2 + $urandom % 15))}, i[2], i[0]);
    end
    repeat (4) @(posedge clk);
    print_verdict();
  end
  initial begin
    #(50 * 10000);
    err_total++;
    print_verdict();
  end
endmodule
